// >>> common/lane_status_pkg.sv
// package with register map, lane status carriers and helpers for the lane status bank
package lane_status_pkg;

  // fixed block dimensions
  localparam int LANE_COUNT = 8;
  localparam int LINK_COUNT = 2;
  localparam int PAGE_W     = 1;

  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_CTRL_ERR   = 12'h46F;
  localparam logic [11:0] IDX_CODE_LOCK  = 12'h470;
  localparam logic [11:0] IDX_FRAME_LOCK = 12'h471;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h474;
  localparam logic [11:0] IDX_IRQ_MASK   = 12'h475;

  // reset values
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;

  // interrupt status and mask bit positions
  localparam int IRQ_CODE_LOST  = 0;
  localparam int IRQ_FRAME_LOST = 1;
  localparam int IRQ_ERR_HIT    = 2;
  localparam int IRQ_W          = 3;

  // raw status of one link as delivered by the lane receivers
  typedef struct packed {
    logic [LANE_COUNT-1:0][7:0] err_count;
    logic [LANE_COUNT-1:0]      code_lock;
    logic [LANE_COUNT-1:0]      frame_lock;
  } lane_status_t;

  // per-lane flags of the selected link, as software reads them
  typedef struct packed {
    logic [LANE_COUNT-1:0] ctrl_err;
    logic [LANE_COUNT-1:0] code_lock;
    logic [LANE_COUNT-1:0] frame_lock;
  } flag_set_t;

  // state of the capture stage
  typedef struct packed {
    flag_set_t         flags;
    logic [PAGE_W-1:0] page;
  } capture_state_t;

  // state of the register bank
  typedef struct packed {
    flag_set_t         seen;
    logic [PAGE_W-1:0] seen_page;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } bank_state_t;

  // error count at or above the threshold
  function automatic logic threshold_hit(input logic [7:0] count, input logic [7:0] threshold);
    return count >= threshold;
  endfunction : threshold_hit

  // byte address of a register index
  function automatic logic [15:0] byte_addr(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : byte_addr

endpackage : lane_status_pkg

// >>> rtl/lane_status_capture.sv
// capture stage: compares error counts and picks the flags of the selected link
`timescale 1ns/1ps
module lane_status_capture
  import lane_status_pkg::*;
(
  input  wire logic                           i_clk,
  input  wire logic                           i_reset_n,
  input  wire lane_status_t [LINK_COUNT-1:0]  i_links,
  input  wire logic [PAGE_W-1:0]              i_link_page,
  input  wire logic [7:0]                     i_threshold,
  output flag_set_t                           o_flags,
  output logic [PAGE_W-1:0]                   o_page
);

  capture_state_t st;
  capture_state_t next_st;

  // flags of the selected link only, one register stage
  always_comb begin
    next_st = st;
    next_st.page = i_link_page;
    for (int n = 0; n < LANE_COUNT; n++) begin
      next_st.flags.ctrl_err[n] = threshold_hit(i_links[i_link_page].err_count[n], i_threshold);
    end
    next_st.flags.code_lock  = i_links[i_link_page].code_lock;
    next_st.flags.frame_lock = i_links[i_link_page].frame_lock;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '{flags: '{FLAGS_RESET, FLAGS_RESET, FLAGS_RESET}, page: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;
  assign o_page  = st.page;

  // helper views of the selected link for checking
  logic [LANE_COUNT-1:0] sel_hit;
  logic [LANE_COUNT-1:0] sel_code;
  always_comb begin
    sel_hit = '0;
    for (int n = 0; n < LANE_COUNT; n++) begin
      sel_hit[n] = i_links[i_link_page].err_count[n] >= i_threshold;
    end
  end
  assign sel_code = i_links[i_link_page].code_lock;

  // compare checks start one edge after release, so only chk_reset_clear compares the reset-held stage
  chk_err_low_lanes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n |=> o_flags.ctrl_err[2:0] == $past(sel_hit[2:0]))
    else $error("low lane error flag disagrees with threshold");
  chk_err_high_lanes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n |=> o_flags.ctrl_err[7:3] == $past(sel_hit[7:3]))
    else $error("upper lane error flag disagrees with threshold");
  chk_page_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_reset_n |=> (o_page == $past(i_link_page)) && (o_flags.code_lock == $past(sel_code)))
    else $error("flags do not follow the selected link");
  chk_reset_clear: assert property (@(posedge i_clk)
    $rose(i_reset_n) |-> (o_flags == '0))
    else $error("status flags not zero after reset");

endmodule : lane_status_capture

// >>> rtl/serial_lane_sync_status_regs.sv
// lane status register bank on APB with lock loss and error interrupts
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - lanes 2..0 error flag is one when count reaches threshold, else zero.
// - code group lock register, bit n is lane n lock, one while held.
// - frame lock register, bit n is lane n, one when frame lock achieved.
// - all flags show the link chosen by the page select, that link only.
// - error flag register also covers lanes 7..3 with the same compare.
// - frame lock bits 1 and 0 report lanes 1 and 0, same encoding.
module serial_lane_sync_status_regs
  import lane_status_pkg::*;
(
  input  wire logic                           i_clk,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [15:0]                    i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  input  wire logic [3:0]                     i_pstrb,
  output logic      [31:0]                    o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  input  wire lane_status_t [LINK_COUNT-1:0]  i_links,
  input  wire logic [PAGE_W-1:0]              i_link_page,
  input  wire logic [7:0]                     i_threshold,
  output logic                                o_irq
);

  flag_set_t          cap_flags;
  logic [PAGE_W-1:0]  cap_page;
  bank_state_t        st;
  bank_state_t        next_st;
  logic               access;
  logic               done;
  logic [IRQ_W-1:0]   events;
  logic [IRQ_W-1:0]   clear;
  logic               same_page;

  // comparison and page selection stage
  lane_status_capture u_capture (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_links     (i_links),
    .i_link_page (i_link_page),
    .i_threshold (i_threshold),
    .o_flags     (cap_flags),
    .o_page      (cap_page)
  );

  // bus phases: one wait state, writes act at the completing edge
  assign access = i_psel & i_penable;
  assign done   = access & st.pready;

  // edge events on the selected view, muted across a page change
  assign same_page = (cap_page == st.seen_page);
  assign events[IRQ_CODE_LOST]  = same_page & (|(st.seen.code_lock & ~cap_flags.code_lock));
  assign events[IRQ_FRAME_LOST] = same_page & (|(st.seen.frame_lock & ~cap_flags.frame_lock));
  assign events[IRQ_ERR_HIT]    = same_page & (|(~st.seen.ctrl_err & cap_flags.ctrl_err));

  // write one to clear the interrupt status
  assign clear = (done && i_pwrite && i_pstrb[0] && i_paddr == byte_addr(IDX_IRQ_STATUS))
               ? i_pwdata[IRQ_W-1:0] : '0;

  // next state of the bank
  always_comb begin
    next_st = st;
    next_st.pready  = access & ~st.pready;
    next_st.pslverr = 1'b0;
    next_st.prdata  = '0;
    if (access && !st.pready) begin
      case (i_paddr)
        byte_addr(IDX_CTRL_ERR): begin
          next_st.prdata = {24'h000000, i_pwrite ? 8'h00 : cap_flags.ctrl_err};
        end
        byte_addr(IDX_CODE_LOCK): begin
          next_st.prdata = {24'h000000, i_pwrite ? 8'h00 : cap_flags.code_lock};
        end
        byte_addr(IDX_FRAME_LOCK): begin
          next_st.prdata = {24'h000000, i_pwrite ? 8'h00 : cap_flags.frame_lock};
        end
        byte_addr(IDX_IRQ_STATUS): begin
          next_st.prdata = {29'h0000000, i_pwrite ? 3'h0 : st.irq_status};
        end
        byte_addr(IDX_IRQ_MASK): begin
          next_st.prdata = {29'h0000000, i_pwrite ? 3'h0 : st.irq_mask};
        end
        default: begin
          next_st.pslverr = 1'b1; // unmapped address
        end
      endcase
    end
    // lane status registers ignore writes; the mask takes one, and the interrupt status takes a write-one-to-clear
    if (done && i_pwrite && i_pstrb[0] && i_paddr == byte_addr(IDX_IRQ_MASK)) begin
      next_st.irq_mask = i_pwdata[IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_st.irq_status = (st.irq_status & ~clear) | events;
    next_st.seen       = cap_flags;
    next_st.seen_page  = cap_page;
    next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '{seen: '{FLAGS_RESET, FLAGS_RESET, FLAGS_RESET}, seen_page: '0,
              irq_status: IRQ_RESET, irq_mask: IRQ_RESET, prdata: 32'h00000000,
              pready: 1'b0, pslverr: 1'b0, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_prdata  = st.prdata;
  assign o_pready  = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_irq     = st.irq;

  // helper views for checking
  logic [7:0] cap_code;
  logic [7:0] cap_frame;
  logic [7:0] cap_err;
  logic       rd_done;
  assign cap_code  = cap_flags.code_lock;
  assign cap_frame = cap_flags.frame_lock;
  assign cap_err   = cap_flags.ctrl_err;
  assign rd_done   = o_pready & i_psel & i_penable & ~i_pwrite;

  chk_read_code_lock: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rd_done && i_paddr == byte_addr(IDX_CODE_LOCK)) |-> o_prdata == {24'h000000, $past(cap_code)})
    else $error("code lock read does not match lane flags");
  chk_read_frame_lock: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rd_done && i_paddr == byte_addr(IDX_FRAME_LOCK)) |-> o_prdata[7:0] == $past(cap_frame))
    else $error("frame lock read does not match lane flags");
  chk_frame_low_lanes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rd_done && i_paddr == byte_addr(IDX_FRAME_LOCK)) |-> o_prdata[1:0] == $past(cap_frame[1:0]))
    else $error("frame lock lanes 1 and 0 misreported");
  chk_read_err_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rd_done && i_paddr == byte_addr(IDX_CTRL_ERR)) |-> o_prdata == {24'h000000, $past(cap_err)})
    else $error("error flag read does not match compare");
  chk_ro_write_ignored: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_pready && i_psel && i_penable && i_pwrite && i_paddr == byte_addr(IDX_CODE_LOCK))
    |-> !o_pslverr ##1 (st.irq_mask == $past(st.irq_mask)))
    else $error("write to read-only register had an effect");
  chk_one_wait_state: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_psel && !i_penable) ##1 (i_psel && i_penable) |-> !o_pready ##1 o_pready)
    else $error("answer not after exactly one wait state");
  chk_set_beats_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (events[IRQ_CODE_LOST] && clear[IRQ_CODE_LOST]) |=> st.irq_status[IRQ_CODE_LOST])
    else $error("lock loss event lost to a clear");
  chk_irq_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (|(events & st.irq_mask)) |=> o_irq)
    else $error("unmasked event did not raise the interrupt");

  cov_code_lock_read: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    rd_done && i_paddr == byte_addr(IDX_CODE_LOCK) && o_prdata != 32'h00000000);
  cov_irq_raised: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_irq));
  cov_page_change: cover property (@(posedge i_clk) disable iff (!i_reset_n) !same_page);
  cov_err_hit: cover property (@(posedge i_clk) disable iff (!i_reset_n) events[IRQ_ERR_HIT]);

endmodule : serial_lane_sync_status_regs

// >>> verification/serial_lane_sync_status_regs_tb.sv
// self-checking bench for the lane status register bank
`timescale 1ns/1ps
module serial_lane_sync_status_regs_tb;
  import lane_status_pkg::*;
  localparam logic [15:0] A_ERR   = {2'b00, IDX_CTRL_ERR, 2'b00};
  localparam logic [15:0] A_CODE  = {2'b00, IDX_CODE_LOCK, 2'b00};
  localparam logic [15:0] A_FRAME = {2'b00, IDX_FRAME_LOCK, 2'b00};
  localparam logic [15:0] A_STAT  = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [15:0] A_MASK  = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam logic [15:0] A_NONE  = 16'h11C8; // hole in the map
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [7:0]        thr;
    logic [7:0]        base;
    logic [7:0]        code;
    logic [7:0]        frame;
  } row_t;
  // selected link, threshold, count of lane 0, lock flags; counts rise by one per lane
  localparam row_t ROWS [4] = '{'{1'b0, 8'h05, 8'h03, 8'hA5, 8'h3C},
                                '{1'b1, 8'h00, 8'h00, 8'h5A, 8'hC3},
                                '{1'b0, 8'hFF, 8'hF8, 8'h0F, 8'hF0},
                                '{1'b1, 8'h10, 8'h08, 8'hF0, 8'h0F}};
  logic                          clk;
  logic                          reset_n;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [15:0]                   paddr;
  logic [31:0]                   pwdata;
  logic [3:0]                    pstrb;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  lane_status_t [LINK_COUNT-1:0] links;
  logic [PAGE_W-1:0]             link_page;
  logic [7:0]                    threshold;
  logic                          irq;
  int                            miscompares;
  int                            checks_done;

  serial_lane_sync_status_regs serial_lane_sync_status_regs_i (
    .i_clk(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_links(links),
    .i_link_page(link_page), .i_threshold(threshold), .o_irq(irq));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                     input logic [3:0] strb, output logic [31:0] rdata, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    pstrb   <= strb;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: no pready", $time);
      complete_run();
    end
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h0, 4'hF, d, e);
    chk_word(d, exp);
    chk_bit(e, exp_err);
  endtask : rd

  task automatic wr(input logic [15:0] addr, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, data, strb, d, e);
    chk_word(d, 32'h0);
    chk_bit(e, 1'b0);
  endtask : wr

  // drives both links; the unselected one carries other counts and inverted locks
  task automatic drive(input row_t r);
    lane_status_t [LINK_COUNT-1:0] t;
    for (int k = 0; k < LINK_COUNT; k++) begin
      for (int n = 0; n < LANE_COUNT; n++) begin
        t[k].err_count[n] = ((k == r.page) ? r.base : r.base ^ 8'h80) + 8'(n);
      end
      t[k].code_lock  = (k == r.page) ? r.code : ~r.code;
      t[k].frame_lock = (k == r.page) ? r.frame : ~r.frame;
    end
    @(posedge clk);
    links     <= t;
    link_page <= r.page;
    threshold <= r.thr;
    repeat (4) @(posedge clk);
  endtask : drive

  function automatic logic [7:0] exp_err(input row_t r);
    for (int n = 0; n < LANE_COUNT; n++) begin
      exp_err[n] = (r.base + 8'(n)) >= r.thr;
    end
  endfunction : exp_err

  initial begin
    row_t r;
    {clk, psel, penable, pwrite, paddr, pwdata, pstrb, links, link_page} = '0;
    reset_n = 1'b0;
    threshold = 8'hFF;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(A_ERR, 32'h0, 1'b0);
    rd(A_CODE, 32'h0, 1'b0);
    rd(A_FRAME, 32'h0, 1'b0);
    foreach (ROWS[i]) begin
      drive(ROWS[i]);
      rd(A_ERR, {24'h0, exp_err(ROWS[i])}, 1'b0);
      rd(A_CODE, {24'h0, ROWS[i].code}, 1'b0);
      rd(A_FRAME, {24'h0, ROWS[i].frame}, 1'b0);
    end
    // interrupt raise, clear and mask
    r = '{1'b0, 8'hFF, 8'h00, 8'hFF, 8'hFF};
    drive(r);
    wr(A_STAT, 32'h7, 4'hF);
    wr(A_MASK, 32'h7, 4'hF);
    rd(A_STAT, 32'h0, 1'b0);
    r.code = 8'hF7;
    drive(r);
    chk_bit(irq, 1'b1);
    rd(A_STAT, 32'h1, 1'b0);
    wr(A_STAT, 32'h1, 4'hF);
    rd(A_STAT, 32'h0, 1'b0);
    chk_bit(irq, 1'b0);
    wr(A_MASK, 32'h1, 4'hF);
    r.frame = 8'hFE;
    r.thr = 8'h00;
    drive(r);
    chk_bit(irq, 1'b0);
    rd(A_STAT, 32'h6, 1'b0);
    wr(A_MASK, 32'h4, 4'h0);
    chk_bit(irq, 1'b0);
    wr(A_MASK, 32'h4, 4'hF);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b1);
    // set beats clear: lane 2 code lock falls in the cycle the clear lands
    fork
      wr(A_STAT, 32'h1, 4'hF);
      begin
        repeat (2) @(posedge clk);
        links[0].code_lock[2] <= 1'b0;
      end
    join
    rd(A_STAT, 32'h7, 1'b0);
    wr(A_CODE, 32'hFF, 4'hF);
    rd(A_CODE, 32'hF3, 1'b0);
    rd(A_NONE, 32'h0, 1'b1);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
    chk_word(prdata, 32'h0);
    chk_bit(pready, 1'b0);
    chk_bit(pslverr, 1'b0);
    reset_n <= 1'b1;
    // error flags rise from their reset zero, so the error event is logged again
    rd(A_STAT, 32'h4, 1'b0);
    rd(A_MASK, 32'h0, 1'b0);
    rd(A_CODE, 32'hF3, 1'b0);
    complete_run();
  end
endmodule : serial_lane_sync_status_regs_tb
